// File: hw/mie_consts.svh
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH
// APB register byte offsets
`define MIE_OFF_CTRL 12'h000
`define MIE_OFF_OPER 12'h004
`define MIE_OFF_ACC 12'h008
`define MIE_OFF_STAT 12'h00c
`define MIE_OFF_RES 12'h010
`define MIE_OFF_TBL 12'h014
// Status field positions
`define MIE_ST_C 0
`define MIE_ST_AC 1
`define MIE_ST_Z 2
`define MIE_ST_OV 3
`define MIE_ST_SKIP 4
`define MIE_ST_MWR 5
`define MIE_ST_DUMMY 6
// Reset value and other constants
`define MIE_ACC_RST 8'h00
`define MIE_ALL_ONES 8'hff
`define MIE_SKIP_CYCLES 2
`endif

// File: hw/mie_pkg.sv
`default_nettype none
package mie_pkg;
  typedef enum logic [4:0] {
    MIE_NOP = 5'h00,
    MIE_SUBTRACT_WITH_BORROW = 5'h01,
    MIE_SUBTRACT_BORROW_TO_MEM = 5'h02,
    MIE_SUB = 5'h03,
    MIE_SUBTRACT_TO_MEM = 5'h04,
    MIE_SUB_IMM = 5'h05,
    MIE_DECREMENT_SKIP_ZERO = 5'h06,
    MIE_DECREMENT_LOAD_SKIP_ZERO = 5'h07,
    MIE_INCREMENT_SKIP_ZERO = 5'h08,
    MIE_INCREMENT_LOAD_SKIP_ZERO = 5'h09,
    MIE_SET_BYTE = 5'h0a,
    MIE_SET_BIT = 5'h0b,
    MIE_BIT_ONE_SKIP = 5'h0c,
    MIE_BYTE_ZERO_SKIP = 5'h0d,
    MIE_LOAD_SKIP_IF_EMPTY = 5'h0e,
    MIE_BIT_ZERO_SKIP = 5'h0f,
    MIE_NIBBLE_EXCHANGE = 5'h10,
    MIE_NIBBLE_EXCHANGE_TO_ACC = 5'h11,
    MIE_TABLE_READ_CURRENT_PAGE = 5'h12,
    MIE_TABLE_READ_LAST_PAGE = 5'h13,
    MIE_XOR = 5'h14,
    MIE_XOR_TO_MEM = 5'h15,
    MIE_XOR_IMM = 5'h16
  } mie_op_e;

  typedef struct packed {
    logic signed_range_flag;
    logic zero;
    logic half_nibble_flag;
    logic carry;
  } mie_flags_s;

  typedef struct packed {
    logic [7:0] operand;
    logic [7:0] immediate;
    logic [2:0] bit_sel;
    logic [4:0] pad;
    mie_op_e op;
  } mie_oper_s;

  typedef struct packed {
    logic dummy;
    logic mem_write;
    logic skip;
  } mie_seq_s;
endpackage
`default_nettype wire

// File: hw/mie_exec.sv
// The register addresses and the APB slave port were chosen for this implementation.
`include "mie_consts.svh"
`default_nettype none
module mie_exec #(
  parameter int ROM_AW = 12,
  parameter int ROM_DW = 15,
  parameter int PAGE_BITS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ROM_AW-1:0] rom_addr,
  input wire logic [ROM_DW-1:0] rom_data,
  input wire logic [ROM_AW-1:0] pc_value,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic skip_next,
  output logic dummy_cycle
);
  localparam int HI_W = ROM_DW - 8;

  logic [7:0] acc;
  mie_pkg::mie_flags_s flags;
  mie_pkg::mie_oper_s oper;
  logic [7:0] rom_index_pointer;
  logic [HI_W-1:0] rom_upper_byte_latch;
  logic [7:0] result;
  mie_pkg::mie_seq_s seq;
  logic go;
  logic busy;

  logic [7:0] next_acc;
  logic [7:0] next_res;
  mie_pkg::mie_flags_s next_flags;
  logic next_skip;
  logic next_mwr;
  logic next_tbl;

  wire logic wr = psel && penable && pwrite;
  wire logic rd_ok = (paddr == `MIE_OFF_CTRL) || (paddr == `MIE_OFF_OPER) ||
      (paddr == `MIE_OFF_ACC) || (paddr == `MIE_OFF_STAT) ||
      (paddr == `MIE_OFF_RES) || (paddr == `MIE_OFF_TBL);

  // Add with carry-in; returns {ov, ac, c, sum}
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
    logic [8:0] s;
    logic [4:0] lo;
    logic ov;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    add8 = {ov, lo[4], s[8], s[7:0]};
  endfunction

  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    swap_nib = {v[3:0], v[7:4]};
  endfunction

  always_comb begin
    logic [10:0] sum;
    logic [7:0] inc;
    logic [7:0] dec;
    logic [7:0] bmask;
    sum = 11'h000;
    inc = oper.operand + 8'h01;
    dec = oper.operand - 8'h01;
    bmask = 8'h01 << oper.bit_sel;
    next_acc = acc;
    next_res = oper.operand;
    next_flags = flags;
    next_skip = 1'b0;
    next_mwr = 1'b0;
    next_tbl = 1'b0;
    unique case (oper.op)
      mie_pkg::MIE_SUBTRACT_WITH_BORROW,
      mie_pkg::MIE_SUBTRACT_BORROW_TO_MEM: begin
        sum = add8(acc, ~oper.operand, flags.carry);
      end
      mie_pkg::MIE_SUB, mie_pkg::MIE_SUBTRACT_TO_MEM: begin
        sum = add8(acc, ~oper.operand, 1'b1);
      end
      mie_pkg::MIE_SUB_IMM: begin
        sum = add8(acc, ~oper.immediate, 1'b1);
      end
      default: begin
        sum = 11'h000;
      end
    endcase
    unique case (oper.op)
      mie_pkg::MIE_NOP: begin
      end
      mie_pkg::MIE_SUBTRACT_WITH_BORROW, mie_pkg::MIE_SUB,
      mie_pkg::MIE_SUB_IMM: begin
        next_acc = sum[7:0];
        next_flags = '{sum[10], sum[7:0] == 8'h00, sum[9], sum[8]};
      end
      mie_pkg::MIE_SUBTRACT_BORROW_TO_MEM,
      mie_pkg::MIE_SUBTRACT_TO_MEM: begin
        next_res = sum[7:0];
        next_mwr = 1'b1;
        next_flags = '{sum[10], sum[7:0] == 8'h00, sum[9], sum[8]};
      end
      mie_pkg::MIE_DECREMENT_SKIP_ZERO: begin
        next_res = dec;
        next_mwr = 1'b1;
        next_skip = (dec == 8'h00);
      end
      mie_pkg::MIE_DECREMENT_LOAD_SKIP_ZERO: begin
        next_acc = dec;
        next_skip = (dec == 8'h00);
      end
      mie_pkg::MIE_INCREMENT_SKIP_ZERO: begin
        next_res = inc;
        next_mwr = 1'b1;
        next_skip = (inc == 8'h00);
      end
      mie_pkg::MIE_INCREMENT_LOAD_SKIP_ZERO: begin
        next_acc = inc;
        next_skip = (inc == 8'h00);
      end
      mie_pkg::MIE_SET_BYTE: begin
        next_res = `MIE_ALL_ONES;
        next_mwr = 1'b1;
      end
      mie_pkg::MIE_SET_BIT: begin
        next_res = oper.operand | bmask;
        next_mwr = 1'b1;
      end
      mie_pkg::MIE_BIT_ONE_SKIP: begin
        next_skip = (oper.operand & bmask) != 8'h00;
      end
      mie_pkg::MIE_BYTE_ZERO_SKIP: begin
        next_skip = (oper.operand == 8'h00);
      end
      mie_pkg::MIE_LOAD_SKIP_IF_EMPTY: begin
        next_acc = oper.operand;
        next_skip = (oper.operand == 8'h00);
      end
      mie_pkg::MIE_BIT_ZERO_SKIP: begin
        next_skip = (oper.operand & bmask) == 8'h00;
      end
      mie_pkg::MIE_NIBBLE_EXCHANGE: begin
        next_res = swap_nib(oper.operand);
        next_mwr = 1'b1;
      end
      mie_pkg::MIE_NIBBLE_EXCHANGE_TO_ACC: begin
        next_acc = swap_nib(oper.operand);
      end
      mie_pkg::MIE_TABLE_READ_CURRENT_PAGE,
      mie_pkg::MIE_TABLE_READ_LAST_PAGE: begin
        next_res = rom_data[7:0];
        next_mwr = 1'b1;
        next_tbl = 1'b1;
      end
      mie_pkg::MIE_XOR: begin
        next_acc = acc ^ oper.operand;
        next_flags.zero = (next_acc == 8'h00);
      end
      mie_pkg::MIE_XOR_TO_MEM: begin
        next_res = acc ^ oper.operand;
        next_mwr = 1'b1;
        next_flags.zero = (next_res == 8'h00);
      end
      mie_pkg::MIE_XOR_IMM: begin
        next_acc = acc ^ oper.immediate;
        next_flags.zero = (next_acc == 8'h00);
      end
      default: begin
      end
    endcase
  end

  // Table address: pointer in the low page bits, page from PC or the top
  always_comb begin
    if (oper.op == mie_pkg::MIE_TABLE_READ_LAST_PAGE) begin
      rom_addr = {{(ROM_AW-PAGE_BITS){1'b1}},
                  rom_index_pointer[PAGE_BITS-1:0]};
    end else begin
      rom_addr = {pc_value[ROM_AW-1:PAGE_BITS],
                  rom_index_pointer[PAGE_BITS-1:0]};
    end
  end

  // Writing the control word with bit 0 set executes one instruction
  assign go = wr && (paddr == `MIE_OFF_CTRL) && pwdata[0] && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper <= '0;
      rom_index_pointer <= 8'h00;
    end else if (wr && paddr == `MIE_OFF_OPER && !busy) begin
      oper <= pwdata[28:0];
    end else if (wr && paddr == `MIE_OFF_TBL && !busy) begin
      rom_index_pointer <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= `MIE_ACC_RST;
      flags <= '0;
    end else if (go) begin
      acc <= next_acc;
      flags <= next_flags;
    end else if (wr && paddr == `MIE_OFF_ACC && !busy) begin
      acc <= pwdata[7:0];
    end else if (wr && paddr == `MIE_OFF_STAT && !busy) begin
      flags <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 8'h00;
      rom_upper_byte_latch <= '0;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_we <= go && next_mwr;
      if (go) begin
        result <= next_res;
        mem_wdata <= next_res;
      end
      if (go && next_tbl) begin
        rom_upper_byte_latch <= rom_data[ROM_DW-1:8];
      end
    end
  end

  // Skip: flag the prefetch as discarded, then one dummy cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= '0;
    end else begin
      seq.mem_write <= go && next_mwr;
      seq.skip <= go && next_skip;
      seq.dummy <= seq.skip;
    end
  end

  assign busy = seq.skip || seq.dummy;
  assign skip_next = seq.skip;
  assign dummy_cycle = seq.dummy;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `MIE_OFF_OPER: prdata <= {3'h0, oper};
        `MIE_OFF_ACC: prdata <= {24'h0, acc};
        `MIE_OFF_STAT: prdata <= {25'h0, seq.dummy, seq.mem_write,
                                  seq.skip, flags};
        `MIE_OFF_RES: prdata <= {24'h0, result};
        `MIE_OFF_TBL: prdata <= {{(24-HI_W){1'b0}}, rom_upper_byte_latch,
                                 rom_index_pointer};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  sequence skip_then_dummy;
    skip_next ##1 (dummy_cycle && !skip_next);
  endsequence

  skip_len_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    skip_next |-> skip_then_dummy ##1 !dummy_cycle)
    else $error("skip did not take exactly two cycles");

  sbc_mem_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_SUBTRACT_BORROW_TO_MEM |=>
    mem_we && acc == $past(acc) &&
    mem_wdata == $past(acc) + ~$past(oper.operand) +
    {7'h00, $past(flags.carry)})
    else $error("borrow subtract to memory wrong");

  dec_wb_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_DECREMENT_SKIP_ZERO |=>
    mem_we && mem_wdata == $past(oper.operand) - 8'h01 &&
    skip_next == (mem_wdata == 8'h00))
    else $error("decrement writeback wrong");

  dec_acc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_DECREMENT_LOAD_SKIP_ZERO |=>
    !mem_we && acc == $past(oper.operand) - 8'h01)
    else $error("decrement to acc wrong");

  inc_flags_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_INCREMENT_SKIP_ZERO |=>
    $stable(flags) && skip_next == (mem_wdata == 8'h00))
    else $error("increment skip wrong");

  set_byte_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_SET_BYTE |=>
    mem_we && mem_wdata == `MIE_ALL_ONES)
    else $error("byte set wrong");

  set_bit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_SET_BIT |=>
    mem_we && mem_wdata ==
    ($past(oper.operand) | (8'h01 << $past(oper.bit_sel))))
    else $error("bit set wrong");

  bit_one_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_BIT_ONE_SKIP |=>
    !mem_we && $stable(flags) && $stable(acc) &&
    skip_next == $past(oper.operand[oper.bit_sel]))
    else $error("bit-one skip wrong");

  load_test_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_LOAD_SKIP_IF_EMPTY |=>
    acc == $past(oper.operand) && skip_next == (acc == 8'h00))
    else $error("load and test wrong");

  swap_mem_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_NIBBLE_EXCHANGE |=>
    mem_we && $stable(flags) &&
    mem_wdata == {$past(oper.operand[3:0]), $past(oper.operand[7:4])})
    else $error("nibble exchange in memory wrong");

  swap_acc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_NIBBLE_EXCHANGE_TO_ACC |=>
    !mem_we && acc == swap_nib($past(oper.operand)))
    else $error("nibble exchange to acc wrong");

  tbl_latch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && next_tbl |=> mem_we && mem_wdata == $past(rom_data[7:0]) &&
    rom_upper_byte_latch == $past(rom_data[ROM_DW-1:8]))
    else $error("table read destinations wrong");

  sub_carry_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_SUB |=>
    acc == $past(acc) - $past(oper.operand) &&
    flags.carry == ($past(acc) >= $past(oper.operand)))
    else $error("subtract result or carry wrong");

  xor_flags_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && oper.op == mie_pkg::MIE_XOR |=>
    flags.carry == $past(flags.carry) &&
    flags.zero == (acc == 8'h00))
    else $error("xor flags wrong");
endmodule
`default_nettype wire

// File: testbench/mie_rom_model.sv
`default_nettype none
module mie_rom_model #(
  parameter int ROM_AW = 12,
  parameter int ROM_DW = 15,
  parameter logic [11:0] PC = 12'h3a5
) (
  input wire logic [ROM_AW-1:0] rom_addr,
  output logic [ROM_DW-1:0] rom_data,
  output logic [ROM_AW-1:0] pc_value
);
  timeunit 1ns;
  timeprecision 1ns;
  // Scrambled contents; page bits reach only the bits above the low byte
  assign rom_data = ROM_DW'(rom_addr * 13 + 7);
  assign pc_value = ROM_AW'(PC);
endmodule
`default_nettype wire

// File: testbench/test_mcu_instr_exec_subset.sv
`include "mie_consts.svh"
`default_nettype none
module test_mcu_instr_exec_subset;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] PC = 12'h3a5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, rom_addr, pc_value;
  logic [31:0] pwdata, prdata, rdv;
  logic [14:0] rom_data;
  logic [7:0] mem_wdata;
  logic mem_we, skip_next, dummy_cycle, last_err;
  int num_errors, checked;

  mie_exec #(.ROM_AW(12), .ROM_DW(15), .PAGE_BITS(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr),
    .rom_data(rom_data), .pc_value(pc_value), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .skip_next(skip_next), .dummy_cycle(dummy_cycle));
  mie_rom_model #(.ROM_AW(12), .ROM_DW(15), .PC(PC)) model (
    .rom_addr(rom_addr), .rom_data(rom_data), .pc_value(pc_value));

  always #10 pclk = ~pclk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t(input mie_pkg::mie_op_e op, input logic [31:0] v);
    logic [7:0] a, m, i, x, r, ea;
    logic [4:0] o, h;
    logic [2:0] b;
    logic [3:0] ef;
    logic [8:0] s;
    logic [11:0] ra;
    logic [14:0] rw;
    logic [31:0] wd;
    logic ci, ewe, esk;
    int nw, ns, nd, at_s, at_d;
    o = op;
    {a, m, i} = v[31:8];
    b = v[6:4];
    ef = v[3:0];
    x = (o == 5'h05 || o == 5'h16) ? i : m;
    ci = (o == 5'h01 || o == 5'h02) ? ef[0] : 1'b1;
    s = {1'b0, a} + {1'b0, ~x} + 9'(ci);
    h = {1'b0, a[3:0]} + {1'b0, ~x[3:0]} + 5'(ci);
    ra = {(o == 5'h13) ? 4'hf : PC[11:8], i};
    rw = 15'(ra * 13 + 7);
    r = m;
    case (o)
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05: begin
        r = s[7:0];
        ef = {a[7] == ~x[7] && s[7] != a[7], r == 8'h00, h[4], s[8]};
      end
      5'h06, 5'h07: r = m - 8'h01;
      5'h08, 5'h09: r = m + 8'h01;
      5'h0a: r = 8'hff;
      5'h0b: r = m | (8'h01 << b);
      5'h10, 5'h11: r = {m[3:0], m[7:4]};
      5'h12, 5'h13: r = rw[7:0];
      5'h14, 5'h15, 5'h16: begin
        r = a ^ x;
        ef[2] = r == 8'h00;
      end
      default: ;
    endcase
    esk = (o inside {[5'h06:5'h09]} && r == 8'h00) || (o == 5'h0c && m[b])
      || (o inside {5'h0d, 5'h0e} && m == 8'h00) || (o == 5'h0f && !m[b]);
    ewe = o inside {5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0b, 5'h10,
                    5'h12, 5'h13, 5'h15};
    ea = (o inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0e, 5'h11,
                    5'h14, 5'h16}) ? r : a;
    apb(1'b1, `MIE_OFF_ACC, 32'(a));
    apb(1'b1, `MIE_OFF_STAT, 32'(v[3:0]));
    apb(1'b1, `MIE_OFF_TBL, 32'(i));
    apb(1'b1, `MIE_OFF_OPER, {3'b0, m, i, b, 5'b0, o});
    apb(1'b1, `MIE_OFF_CTRL, 32'h1);
    nw = 0;
    ns = 0;
    nd = 0;
    at_s = 0;
    at_d = 0;
    wd = 0;
    // Pulses launched by the execute edge stand for one cycle only
    for (int k = 0; k < 4; k++) begin
      #1;
      if (mem_we === 1'b1) begin
        nw++;
        wd = 32'(mem_wdata);
      end
      if (skip_next === 1'b1) begin
        ns++;
        at_s = k;
      end
      if (dummy_cycle === 1'b1) begin
        nd++;
        at_d = k;
      end
      @(posedge pclk);
    end
    chk(32'(nw), 32'(ewe));
    if (ewe) chk(wd, 32'(r));
    chk(32'(ns), 32'(esk));
    chk(32'(nd), 32'(esk));
    if (esk) chk(32'(at_d), 32'(at_s + 1));
    apb(1'b0, `MIE_OFF_ACC, 32'h0);
    chk(rdv & 32'hff, 32'(ea));
    apb(1'b0, `MIE_OFF_STAT, 32'h0);
    chk(rdv & 32'hf, 32'(ef));
    if (o inside {5'h12, 5'h13}) begin
      apb(1'b0, `MIE_OFF_TBL, 32'h0);
      chk(32'(rdv[14:8]), 32'(rw[14:8]));
    end
    $display("test op %h done", o);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MIE_OFF_ACC, 32'h0);
    chk(rdv, 32'(`MIE_ACC_RST));
    // Unmapped word answers zero with an error
    apb(1'b0, 12'h018, 32'h0);
    chk(rdv, 32'h0);
    chk(32'(last_err), 32'h1);
    t(mie_pkg::MIE_NOP, 32'h12340005);
    t(mie_pkg::MIE_SUBTRACT_WITH_BORROW, 32'h10010000);
    t(mie_pkg::MIE_SUBTRACT_WITH_BORROW, 32'h10010001);
    t(mie_pkg::MIE_SUBTRACT_BORROW_TO_MEM, 32'h00010001);
    t(mie_pkg::MIE_SUB, 32'h80010000);
    t(mie_pkg::MIE_SUBTRACT_TO_MEM, 32'h05050000);
    t(mie_pkg::MIE_SUB_IMM, 32'h3c000d00);
    t(mie_pkg::MIE_DECREMENT_SKIP_ZERO, 32'h00010000);
    t(mie_pkg::MIE_DECREMENT_SKIP_ZERO, 32'h0000000f);
    t(mie_pkg::MIE_DECREMENT_LOAD_SKIP_ZERO, 32'h33010000);
    t(mie_pkg::MIE_INCREMENT_SKIP_ZERO, 32'h00ff0000);
    t(mie_pkg::MIE_INCREMENT_SKIP_ZERO, 32'h007f0005);
    t(mie_pkg::MIE_INCREMENT_LOAD_SKIP_ZERO, 32'h33ff0000);
    t(mie_pkg::MIE_SET_BYTE, 32'h005a000f);
    t(mie_pkg::MIE_SET_BIT, 32'h00a50010);
    t(mie_pkg::MIE_SET_BIT, 32'h00000070);
    t(mie_pkg::MIE_BIT_ONE_SKIP, 32'h00080030);
    t(mie_pkg::MIE_BIT_ONE_SKIP, 32'h00f70030);
    t(mie_pkg::MIE_BYTE_ZERO_SKIP, 32'h00000000);
    t(mie_pkg::MIE_BYTE_ZERO_SKIP, 32'h00800000);
    t(mie_pkg::MIE_LOAD_SKIP_IF_EMPTY, 32'h77000000);
    t(mie_pkg::MIE_LOAD_SKIP_IF_EMPTY, 32'h77420000);
    t(mie_pkg::MIE_BIT_ZERO_SKIP, 32'h00fe0000);
    t(mie_pkg::MIE_BIT_ZERO_SKIP, 32'h00010000);
    t(mie_pkg::MIE_NIBBLE_EXCHANGE, 32'h003c000a);
    t(mie_pkg::MIE_NIBBLE_EXCHANGE_TO_ACC, 32'h11a50000);
    t(mie_pkg::MIE_TABLE_READ_CURRENT_PAGE, 32'h00007e00);
    t(mie_pkg::MIE_TABLE_READ_LAST_PAGE, 32'h0000ff00);
    t(mie_pkg::MIE_XOR, 32'h5a5a0000);
    t(mie_pkg::MIE_XOR_TO_MEM, 32'hf00f000f);
    t(mie_pkg::MIE_XOR_IMM, 32'haa005504);
    report_and_stop();
  end

  // About twelve times the expected run length
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
